// *** bench/ipsc_host_model.sv ***
// host side of the irq pins: pull resistors and the resolved level
// assumes the bench chooses pull-up or pull-down per pin
`timescale 1ns/1ns
module ipsc_host_model (
	input wire [1:0] irq_pin_out,
	input wire [1:0] irq_pin_oe_n,
	input wire [1:0] pull_level,
	output wire [1:0] irq_level
);
	// released pin falls to the resistor, never the last driven value
	assign irq_level = (irq_pin_out & ~irq_pin_oe_n)
		| (pull_level & irq_pin_oe_n);
endmodule // ipsc_host_model

// *** bench/ipsc_irq_pin_and_sensor_config_tb.sv ***
// self-checking bench for the interrupt pin and config block
// assumes boot counts shortened to 5 cycles
`timescale 1ns/1ns
`include "ipsc_defs.vh"
module ipsc_irq_pin_and_sensor_config_tb;
	logic clock = 0, reset = 1, soft_reset = 0, boot_strap_level = 0;
	logic cs_wake_pin = 1, motion_level_pin = 0, reg_wr_en = 0;
	logic odr_tick = 0, change_detect_mode = 0, autoinc_load = 0;
	logic autoinc_step = 0, ext_trigger = 0, measure_done = 0;
	logic [7:0] reg_addr = 0, reg_wr_data = 0, autoinc_start = 0;
	logic [1:0] irq_event = 0, pull_level = 2'h3;
	logic sleep_state = 0;
	logic [7:0] decimation_count = 8'h02;
	logic [11:0] x_data = 0, y_data = 0, z_data = 0;
	wire [7:0] reg_rd_data, autoinc_ptr;
	wire [1:0] irq_pin_out, irq_pin_oe_n, active_power_mode, irq_level;
	wire [11:0] magnitude_result, change_detect_src;
	wire magnitude_valid, measure_req, device_powered, device_ready;
	wire motion_detect_active;
	int num_errors = 0, checks_done = 0, i, j;
	always #50 clock = ~clock;
	ipsc_irq_pin_and_sensor_config #(.FIRST_BOOT_CYCLES(5),
		.SECOND_BOOT_CYCLES(5)) ipsc_irq_pin_and_sensor_config_inst (
		.clock, .reset, .soft_reset, .boot_strap_level, .cs_wake_pin,
		.motion_level_pin, .reg_addr, .reg_wr_en, .reg_wr_data,
		.reg_rd_data, .irq_event, .irq_pin_out, .irq_pin_oe_n, .odr_tick,
		.x_data, .y_data, .z_data, .magnitude_result, .magnitude_valid,
		.change_detect_mode, .change_detect_src, .autoinc_load,
		.autoinc_step, .autoinc_start, .autoinc_ptr, .ext_trigger,
		.decimation_count, .measure_done, .measure_req,
		.sleep_state, .wake_power_mode(2'h2),
		.sleep_power_mode(2'h1), .active_power_mode, .device_powered,
		.device_ready, .motion_detect_active);
	ipsc_host_model ipsc_host_model_inst (.irq_pin_out, .irq_pin_oe_n,
		.pull_level, .irq_level);
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic to(input logic ok);
		chk(ok, 1'b1);
		if (ok !== 1'b1)
			summarize;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1;
		@(negedge clock);
		reg_wr_en = 0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock);
		reg_addr = a;
		repeat (2) @(negedge clock);
		chk(reg_rd_data, exp);
	endtask
	task automatic t_regs;
		rc(8'h19, 8'h00);
		rc(8'h20, 8'h01);
		chk(active_power_mode, 2'h2);
		sleep_state = 1;
		repeat (2) @(negedge clock);
		chk(active_power_mode, 2'h1);
		sleep_state = 0;
		wr(8'h19, 8'hFE);
		rc(8'h19, 8'h1E);
		wr(8'h20, 8'h02);
		soft_reset = 1;
		@(negedge clock);
		soft_reset = 0;
		rc(8'h19, 8'h00);
		rc(8'h20, 8'h02);
	endtask
	task automatic t_pins;
		for (i = 0; i < 8; i++) begin
			wr(8'h20, {6'h00, i[2:1]});
			pull_level = {2{~i[1]}};
			irq_event = {2{i[0]}};
			repeat (3) @(negedge clock);
			chk(irq_level, {2{i[1] ~^ i[0]}});
			chk(irq_pin_oe_n, {2{i[2] & ~i[0]}});
		end
		irq_event = 0;
	endtask
	task automatic t_auto;
		logic [23:0] tbl [4] = '{24'h0E_030C, 24'h10_090A,
			24'h08_0306, 24'h00_090C};
		for (i = 0; i < 4; i++) begin
			wr(8'h19, tbl[i][23:16]);
			autoinc_start = tbl[i][15:8];
			autoinc_load = 1;
			@(negedge clock);
			autoinc_load = 0;
			autoinc_step = 1;
			@(negedge clock);
			autoinc_step = 0;
			@(negedge clock);
			chk(autoinc_ptr, tbl[i][7:0]);
		end
	endtask
	task automatic t_mag;
		wr(8'h19, 8'h10);
		x_data = 12'h003;
		y_data = 12'h004;
		change_detect_mode = 1;
		odr_tick = 1;
		@(negedge clock);
		odr_tick = 0;
		for (i = 0; i < 40 && magnitude_valid !== 1'b1; i++)
			@(negedge clock);
		to(magnitude_valid);
		chk(i, 13);
		chk(magnitude_result, 12'h005);
		repeat (2) @(negedge clock);
		chk(change_detect_src, 12'h005);
		change_detect_mode = 0;
		wr(8'h19, 8'h00);
		odr_tick = 1;
		for (i = 0; i < 20; i++) begin
			@(negedge clock);
			odr_tick = 0;
			chk(magnitude_valid, 1'b0);
		end
		chk(change_detect_src, x_data);
	endtask
	task automatic t_trig;
		ext_trigger = 1;
		@(negedge clock);
		ext_trigger = 0;
		for (i = 0; i < 2; i++) begin
			chk(measure_req, 1'b1);
			measure_done = 1;
			@(negedge clock);
			measure_done = 0;
			@(negedge clock);
		end
		chk(measure_req, 1'b0);
		decimation_count = 8'h00;
		ext_trigger = 1;
		@(negedge clock);
		ext_trigger = 0;
		@(negedge clock);
		chk(measure_req, 1'b0);
		decimation_count = 8'h02;
	endtask
	task automatic t_deep;
		// both wake edge directions
		for (j = 0; j < 2; j++) begin
			wr(8'h20, 8'h02);
			wr(8'h19, 8'h01);
			repeat (4) @(negedge clock);
			chk(device_powered, 1'b0);
			cs_wake_pin = ~cs_wake_pin;
			for (i = 0; i < 40 && device_ready !== 1'b1; i++)
				@(negedge clock);
			to(device_ready);
			rc(8'h20, 8'h01);
		end
	endtask
	task automatic t_strap;
		boot_strap_level = 1;
		for (i = 0; i < 40 && device_powered !== 1'b0; i++)
			@(negedge clock);
		to(!device_powered);
		motion_level_pin = 1;
		for (i = 0; i < 40 && device_ready !== 1'b1; i++)
			@(negedge clock);
		to(device_ready);
		chk(motion_detect_active, 1'b1);
		pull_level = 2'h3;
		irq_event = 2'h3;
		repeat (3) @(negedge clock);
		chk(irq_level, 2'h0);
		irq_event = 2'h0;
		repeat (3) @(negedge clock);
		chk(irq_pin_oe_n, 2'h3);
		chk(irq_level, 2'h3);
		motion_level_pin = 0;
		repeat (12) @(negedge clock);
		chk(device_powered, 1'b0);
	endtask
	initial begin
		repeat (20) @(negedge clock);
		reset = 0;
		@(negedge clock);
		t_regs;
		t_pins;
		t_auto;
		t_mag;
		t_trig;
		t_deep;
		t_strap;
		summarize;
	end
endmodule // ipsc_irq_pin_and_sensor_config_tb

// *** bench/ipsc_monitor.sv ***
// assertions on the ports of the interrupt pin and config block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module ipsc_monitor (
	input wire clock,
	input wire reset,
	input wire [11:0] x_data,
	input wire [11:0] change_detect_src,
	input wire change_detect_mode,
	input wire odr_tick,
	input wire magnitude_valid,
	input wire ext_trigger,
	input wire measure_done,
	input wire measure_req,
	input wire [7:0] decimation_count,
	input wire autoinc_load,
	input wire [7:0] autoinc_start,
	input wire [7:0] autoinc_ptr,
	input wire [1:0] irq_pin_out,
	input wire [1:0] irq_pin_oe_n,
	input wire device_powered,
	input wire device_ready,
	input wire motion_detect_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	released_off_a: assert property (!device_powered
		|-> irq_pin_oe_n == 2'h3)
		else $error("irq pin driven while powered down");
	mag_delay_a: assert property (magnitude_valid
		|-> $past(odr_tick, 14))
		else $error("magnitude result without tick 14 cycles before");
	cd_source_a: assert property (!$past(reset) && $past(device_ready)
		&& !$past(change_detect_mode) |-> change_detect_src == $past(x_data))
		else $error("change detect source not x data");
	trig_start_a: assert property (!$past(reset) && $past(ext_trigger)
		&& !$past(measure_req) && $past(decimation_count) != 8'h00
		&& $past(device_ready) |-> measure_req)
		else $error("trigger did not start acquisition");
	req_hold_a: assert property (!$past(reset) && $fell(measure_req)
		&& device_powered |-> $past(measure_done))
		else $error("acquisition ended without a finished measurement");
	ptr_load_a: assert property (!$past(reset) && $past(autoinc_load)
		&& $past(device_ready) |-> autoinc_ptr == $past(autoinc_start))
		else $error("pointer load lost");
	strap_pin_a: assert property (motion_detect_active
		|-> (irq_pin_out & ~irq_pin_oe_n) == 2'h0)
		else $error("strap mode pin driven high");
	ready_power_a: assert property (!device_powered |-> !device_ready)
		else $error("ready while powered down");
endmodule // ipsc_monitor

bind ipsc_irq_pin_and_sensor_config ipsc_monitor ipsc_monitor_inst (
	.clock, .reset, .x_data, .change_detect_src, .change_detect_mode,
	.odr_tick, .magnitude_valid, .ext_trigger, .measure_done, .measure_req,
	.decimation_count, .autoinc_load, .autoinc_start, .autoinc_ptr,
	.irq_pin_out, .irq_pin_oe_n, .device_powered, .device_ready,
	.motion_detect_active);

// *** logic/ipsc_defs.vh ***
// constants of the interrupt pin and sensor configuration block
// assumes a 10 MHz core clock and byte-wide register access
`ifndef IPSC_DEFS_VH
`define IPSC_DEFS_VH

`define IPSC_SENSOR_CONFIG_FIVE_ADDR 8'h19
`define IPSC_IRQ_PIN_CONFIG_ADDR 8'h20
`define IPSC_CFG5_RESET 8'h00
`define IPSC_CFG5_MASK 8'h1F
`define IPSC_BIT_MAG_EN 4
`define IPSC_BIT_X_SKIP 3
`define IPSC_BIT_Y_SKIP 2
`define IPSC_BIT_Z_SKIP 1
`define IPSC_BIT_DEEP_OFF 0
`define IPSC_BIT_DRIVER_TYPE 1
`define IPSC_BIT_POLARITY 0
`define IPSC_DRIVER_TYPE_RESET 1'b0
`define IPSC_POLARITY_RESET 1'b1

// data addresses walked by auto-increment reads
`define IPSC_X_LOW_ADDR 8'h04
`define IPSC_Y_LOW_ADDR 8'h06
`define IPSC_Z_LOW_ADDR 8'h08
`define IPSC_MAG_LOW_ADDR 8'h0A

`define IPSC_CLOCK_MHZ 10
`define IPSC_FIRST_BOOT_WAIT_US 1000
`define IPSC_SECOND_BOOT_WAIT_US 1000

`endif

// *** logic/ipsc_irq_pin_and_sensor_config.v ***
// interrupt pin drivers, sensor config five, deep-off sequencing
// assumes register writes come from the serial engine on the same clock
`timescale 1ns/1ns
`include "ipsc_defs.vh"

module ipsc_irq_pin_and_sensor_config #(
	parameter FIRST_BOOT_CYCLES =
		`IPSC_FIRST_BOOT_WAIT_US * `IPSC_CLOCK_MHZ,
	parameter SECOND_BOOT_CYCLES =
		`IPSC_SECOND_BOOT_WAIT_US * `IPSC_CLOCK_MHZ
) (
	input wire clock,
	input wire reset,
	input wire soft_reset,
	input wire boot_strap_level,
	input wire cs_wake_pin,
	input wire motion_level_pin,
	input wire [7:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wr_data,
	output reg [7:0] reg_rd_data,
	input wire [1:0] irq_event,
	output reg [1:0] irq_pin_out,
	output reg [1:0] irq_pin_oe_n,
	input wire odr_tick,
	input wire [11:0] x_data,
	input wire [11:0] y_data,
	input wire [11:0] z_data,
	output reg [11:0] magnitude_result,
	output reg magnitude_valid,
	input wire change_detect_mode,
	output reg [11:0] change_detect_src,
	input wire autoinc_load,
	input wire autoinc_step,
	input wire [7:0] autoinc_start,
	output reg [7:0] autoinc_ptr,
	input wire ext_trigger,
	input wire [7:0] decimation_count,
	input wire measure_done,
	output reg measure_req,
	input wire sleep_state,
	input wire [1:0] wake_power_mode,
	input wire [1:0] sleep_power_mode,
	output reg [1:0] active_power_mode,
	output reg device_powered,
	output reg device_ready,
	output reg motion_detect_active
);
	localparam ST_ON = 3'b001;
	localparam ST_OFF = 3'b010;
	localparam ST_BOOT = 3'b100;

	reg [2:0] strap_sync;
	reg [2:0] wake_sync;
	reg [2:0] motion_sync;
	reg strap_f;
	reg wake_f;
	reg motion_f;
	reg [2:0] state;
	reg [31:0] boot_count;
	reg wake_level_at_entry;
	reg [7:0] cfg5;
	reg irq_driver_type_sel;
	reg irq_polarity_sel;
	reg [25:0] mag_sum;
	reg [12:0] mag_root;
	reg [3:0] mag_bit;
	reg mag_busy;
	reg [7:0] acq_left;
	wire magnitude_calc_en = cfg5[`IPSC_BIT_MAG_EN];
	wire x_axis_skip = cfg5[`IPSC_BIT_X_SKIP];
	wire y_axis_skip = cfg5[`IPSC_BIT_Y_SKIP];
	wire z_axis_skip = cfg5[`IPSC_BIT_Z_SKIP];
	wire on = (state == ST_ON);
	wire cfg5_wr = on && reg_wr_en &&
		reg_addr == `IPSC_SENSOR_CONFIG_FIVE_ADDR;
	wire pin_wr = on && reg_wr_en && reg_addr == `IPSC_IRQ_PIN_CONFIG_ADDR;
	wire deep_off_cmd = cfg5_wr && !strap_f &&
		reg_wr_data[`IPSC_BIT_DEEP_OFF];
	wire motion_off = on && strap_f && !motion_f;
	wire [11:0] ax = x_data[11] ? (~x_data + 12'h001) : x_data;
	wire [11:0] ay = y_data[11] ? (~y_data + 12'h001) : y_data;
	wire [11:0] az = z_data[11] ? (~z_data + 12'h001) : z_data;
	wire [23:0] sq_x = {12'h000, ax} * {12'h000, ax};
	wire [23:0] sq_y = {12'h000, ay} * {12'h000, ay};
	wire [23:0] sq_z = {12'h000, az} * {12'h000, az};
	wire [25:0] sum_sq = {2'b00, sq_x} + {2'b00, sq_y} + {2'b00, sq_z};
	wire [12:0] trial_root = mag_root | (13'h0001 << mag_bit);
	wire [25:0] trial_sq = trial_root * trial_root;

	// skip the pairs that are switched off; at most four pairs in a row
	function [7:0] next_addr;
		input [7:0] a;
		input xs;
		input ys;
		input zs;
		input me;
		integer i;
		reg [7:0] n;
		begin
			n = a + 8'h01;
			for (i = 0; i < 4; i = i + 1) begin
				if (xs && {n[7:1], 1'b0} == `IPSC_X_LOW_ADDR)
					n = n + 8'h02;
				else if (ys && {n[7:1], 1'b0} == `IPSC_Y_LOW_ADDR)
					n = n + 8'h02;
				else if (zs && {n[7:1], 1'b0} == `IPSC_Z_LOW_ADDR)
					n = n + 8'h02;
				else if (!me && {n[7:1], 1'b0} == `IPSC_MAG_LOW_ADDR)
					n = n + 8'h02;
			end
			next_addr = n;
		end
	endfunction

	// pins settle as soon as the second and third stages agree
	always @(posedge clock) begin
		if (reset) begin
			strap_sync <= 3'b000;
			wake_sync <= 3'b000;
			motion_sync <= 3'b000;
			strap_f <= 1'b0;
			wake_f <= 1'b0;
			motion_f <= 1'b0;
		end else begin
			strap_sync <= {strap_sync[1:0], boot_strap_level};
			wake_sync <= {wake_sync[1:0], cs_wake_pin};
			motion_sync <= {motion_sync[1:0], motion_level_pin};
			if (strap_sync[1] == strap_sync[2])
				strap_f <= strap_sync[2];
			if (wake_sync[1] == wake_sync[2])
				wake_f <= wake_sync[2];
			if (motion_sync[1] == motion_sync[2])
				motion_f <= motion_sync[2];
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			state <= ST_ON;
			boot_count <= 32'h0000_0000;
			wake_level_at_entry <= 1'b0;
		end else begin
			case (state)
			ST_ON: begin
				if (deep_off_cmd) begin
					state <= ST_OFF;
					wake_level_at_entry <= wake_f;
				end else if (motion_off) begin
					state <= ST_OFF;
				end
			end
			ST_OFF: begin
				if (!strap_f && wake_f != wake_level_at_entry) begin
					state <= ST_BOOT;
					boot_count <= FIRST_BOOT_CYCLES;
				end else if (strap_f && motion_f) begin
					state <= ST_BOOT;
					boot_count <= SECOND_BOOT_CYCLES;
				end
			end
			ST_BOOT: begin
				if (boot_count <= 32'h0000_0001)
					state <= ST_ON;
				boot_count <= boot_count - 32'h0000_0001;
			end
			default: state <= ST_ON;
			endcase
		end
	end

	// soft reset spares the pin settings; deep-off does not
	always @(posedge clock) begin
		if (reset || state != ST_ON) begin
			irq_driver_type_sel <= `IPSC_DRIVER_TYPE_RESET;
			irq_polarity_sel <= `IPSC_POLARITY_RESET;
		end else if (pin_wr) begin
			irq_driver_type_sel <= reg_wr_data[`IPSC_BIT_DRIVER_TYPE];
			irq_polarity_sel <= reg_wr_data[`IPSC_BIT_POLARITY];
		end
	end

	always @(posedge clock) begin
		if (reset || soft_reset || state != ST_ON)
			cfg5 <= `IPSC_CFG5_RESET;
		else if (cfg5_wr)
			cfg5 <= reg_wr_data & `IPSC_CFG5_MASK;
	end

	always @(posedge clock) begin
		if (reset)
			reg_rd_data <= 8'h00;
		else if (reg_addr == `IPSC_SENSOR_CONFIG_FIVE_ADDR)
			reg_rd_data <= cfg5;
		else if (reg_addr == `IPSC_IRQ_PIN_CONFIG_ADDR)
			reg_rd_data <= {6'h00, irq_driver_type_sel, irq_polarity_sel};
		else
			reg_rd_data <= 8'h00;
	end

	// pins are released while powered down so nothing back-drives the host
	always @(posedge clock) begin
		if (reset || state != ST_ON) begin
			irq_pin_out <= 2'b00;
			irq_pin_oe_n <= 2'b11;
		end else if (strap_f) begin
			irq_pin_out <= 2'b00;
			irq_pin_oe_n <= ~irq_event;
		end else if (irq_driver_type_sel) begin
			irq_pin_out <= {2{irq_polarity_sel}};
			irq_pin_oe_n <= ~irq_event;
		end else begin
			irq_pin_out <= irq_event ^ {2{~irq_polarity_sel}};
			irq_pin_oe_n <= 2'b00;
		end
	end

	// bitwise square root, 14 cycles per sample (load plus 13 bit steps); fine at kHz data rates
	always @(posedge clock) begin
		if (reset || state != ST_ON) begin
			mag_sum <= 26'h000_0000;
			mag_root <= 13'h0000;
			mag_bit <= 4'h0;
			mag_busy <= 1'b0;
			magnitude_result <= 12'h000;
			magnitude_valid <= 1'b0;
		end else begin
			magnitude_valid <= 1'b0;
			if (!mag_busy && odr_tick && magnitude_calc_en) begin
				mag_sum <= sum_sq;
				mag_root <= 13'h0000;
				mag_bit <= 4'hC;
				mag_busy <= 1'b1;
			end else if (mag_busy) begin
				if (trial_sq <= mag_sum)
					mag_root <= trial_root;
				if (mag_bit == 4'h0) begin
					mag_busy <= 1'b0;
					magnitude_valid <= 1'b1;
					magnitude_result <= (trial_sq <= mag_sum) ?
						(trial_root[12] ? 12'hFFF : trial_root[11:0]) :
						(mag_root[12] ? 12'hFFF : mag_root[11:0]);
				end else begin
					mag_bit <= mag_bit - 4'h1;
				end
			end
		end
	end

	always @(posedge clock) begin
		if (reset)
			change_detect_src <= 12'h000;
		else if (change_detect_mode)
			change_detect_src <= magnitude_result;
		else
			change_detect_src <= x_data;
	end

	always @(posedge clock) begin
		if (reset)
			autoinc_ptr <= 8'h00;
		else if (autoinc_load)
			autoinc_ptr <= autoinc_start;
		else if (autoinc_step)
			autoinc_ptr <= next_addr(autoinc_ptr, x_axis_skip,
				y_axis_skip, z_axis_skip, magnitude_calc_en);
	end

	// a new trigger while busy is ignored
	always @(posedge clock) begin
		if (reset || state != ST_ON) begin
			acq_left <= 8'h00;
			measure_req <= 1'b0;
		end else if (acq_left == 8'h00) begin
			measure_req <= ext_trigger && decimation_count != 8'h00;
			if (ext_trigger)
				acq_left <= decimation_count;
		end else if (measure_done) begin
			acq_left <= acq_left - 8'h01;
			measure_req <= acq_left != 8'h01;
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			active_power_mode <= 2'b00;
			device_powered <= 1'b0;
			device_ready <= 1'b0;
			motion_detect_active <= 1'b0;
		end else begin
			active_power_mode <= sleep_state ? sleep_power_mode :
				wake_power_mode;
			device_powered <= state != ST_OFF;
			device_ready <= on;
			motion_detect_active <= on && strap_f;
		end
	end
endmodule // ipsc_irq_pin_and_sensor_config
